// ---- design/ulpm_status.sv ----
/*
 * Link power management status logic of a dual role USB controller:
 * register port, host request sequencer, device responder, event flags.
 * Assumes link inputs synchronous to i_core_clk and single-cycle strobes.
 */
`timescale 1ns/10ps
`include "ulpm_cfg.svh"

// Behaviour
// RL1 - device: endpoint field holds endpoint 0..7 of last received request
// RL2 - host: endpoint field holds endpoint of the last request sent
// RL3 - host: three failed attempts by timeout or bit error set the unfinished flag
// RL4 - host: bus error while sending a request sets the fault flag
// RL5 - host: ACK, NYET or STALL answer sets accepted, deferred or refused flag
// RL6 - both modes: leaving the low power state sets the wakeup flag
// RL7 - device: unsupported link state is stalled, faulted, and still captured
// RL8 - device: pending transmit data gives NYET and the unfinished flag; with response disabled the code sets the deferred flag instead
// RL9 - device: acknowledging a request enters suspend and sets the accepted flag
// RL10 - device: response disabled gives NYET and the deferred flag
// RL11 - device: every stalled request sets the refused flag
// RL12 - each flag reaches the interrupt only while its enable bit is set
// RL13 - reading status clears all flags; later events remain
// RL14 - host: configured link state is sent in every request
// RL15 - device: link state field captures last request, acknowledged or stalled
// RL16 - host: remote wake bit reflects setting sent in requests
// RL17 - device: remote wake bit captures permission of last received request
// RL18 - device: entering sleep clears the response enable
// RL19 - host: resume drive lasts 50us plus 75us steps, up to 1175us
// RL20 - host: request targets device address 1..127 and an endpoint
// RL21 - six flags sit at fixed distinct positions in status and enable
module ulpm_status
	import ulpm_pkg::*;
#(
	parameter int P_RES_BASE_CYC = `ULPM_RES_BASE_CYC,
	parameter int P_RES_STEP_CYC = `ULPM_RES_STEP_CYC
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [`ULPM_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_irq,
	input wire logic i_rx_lpm_valid,
	input wire logic [2:0] i_rx_endpoint_index,
	input wire logic [3:0] i_rx_link_state,
	input wire logic i_rx_remote_wake,
	input wire logic i_tx_fifo_pending,
	output logic o_dev_resp_valid,
	output ulpm_dev_resp_t o_dev_resp,
	output logic o_dev_remote_wake,
	input wire logic i_bus_resume,
	output logic o_host_lpm_req,
	output logic [6:0] o_host_dev_addr,
	output logic [2:0] o_host_endpoint_index,
	output logic [3:0] o_host_link_state,
	output logic o_host_remote_wake,
	input wire logic i_host_resp_valid,
	input wire ulpm_host_resp_t i_host_resp,
	input wire logic i_host_bus_err,
	output logic o_resume_drive,
	output logic o_lpm_sleep
);

	// ------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [`ULPM_NFLAGS-1:0] ien_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic wr_ctrl;
	logic wr_cmd;
	logic wr_ien;
	logic rd_status;
	logic host_mode;
	logic cmd_send;
	logic cmd_wake;

	assign wr_ctrl = i_wr && (i_addr == `ULPM_OFS_CTRL);
	assign wr_cmd = i_wr && (i_addr == `ULPM_OFS_CMD);
	assign wr_ien = i_wr && (i_addr == `ULPM_OFS_IEN);
	assign rd_status = i_rd && (i_addr == `ULPM_OFS_STATUS);
	assign host_mode = ctrl_r[`ULPM_CTRL_HOST];
	assign cmd_send = wr_cmd && i_wdata[`ULPM_CMD_SEND];
	assign cmd_wake = wr_cmd && i_wdata[`ULPM_CMD_WAKE];

	// ------------------------------------------------------------
	// host configuration fields
	// ------------------------------------------------------------
	logic [3:0] cfg_link_state;
	logic [2:0] cfg_endpoint;
	logic [6:0] cfg_dev_addr;
	logic [3:0] cfg_rtime;
	logic cfg_rwake;
	logic [31:0] ctrl_wr_val;

	assign cfg_link_state = ctrl_r[`ULPM_CTRL_LS_LO +: 4];
	assign cfg_endpoint = ctrl_r[`ULPM_CTRL_EP_LO +: 3];
	assign cfg_dev_addr = ctrl_r[`ULPM_CTRL_ADDR_LO +: 7];
	assign cfg_rtime = ctrl_r[`ULPM_CTRL_RTIME_LO +: 4];
	assign cfg_rwake = ctrl_r[`ULPM_CTRL_RWAKE];
	// only implemented fields are kept; address 0 is not a valid target
	assign ctrl_wr_val = {8'h00, i_wdata[`ULPM_CTRL_RTIME_LO +: 4], 1'b0,
		(i_wdata[`ULPM_CTRL_ADDR_LO +: 7] == 7'h00) ? cfg_dev_addr : i_wdata[`ULPM_CTRL_ADDR_LO +: 7], // [RL20]
		1'b0, i_wdata[`ULPM_CTRL_EP_LO +: 3], i_wdata[`ULPM_CTRL_LS_LO +: 4], 1'b0,
		i_wdata[2:0]};

	// ------------------------------------------------------------
	// device responder
	// ------------------------------------------------------------
	logic dev_rx;
	logic ls_bad;
	logic dev_stall;
	logic dev_nyet_off;
	logic dev_nyet_busy;
	logic dev_ack;
	logic dev_wake;
	logic dev_sleep_r;
	logic [2:0] rx_ep_r;
	logic [3:0] rx_ls_r;
	logic rx_rwake_r;
	logic dev_resp_valid_r;
	ulpm_dev_resp_t dev_resp_r;
	ulpm_dev_resp_t dev_resp_nxt;
	logic dev_rwake_r;

	assign dev_rx = i_rx_lpm_valid && !host_mode && !dev_sleep_r;
	assign ls_bad = i_rx_link_state != `ULPM_SLEEP_LINK_STATE;
	assign dev_stall = dev_rx && ls_bad; // [RL7] [RL11]
	assign dev_nyet_off = dev_rx && !ls_bad && !ctrl_r[`ULPM_CTRL_RESP_EN]; // [RL10]
	assign dev_nyet_busy = dev_rx && !ls_bad && ctrl_r[`ULPM_CTRL_RESP_EN] && i_tx_fifo_pending; // [RL8]
	assign dev_ack = dev_rx && !ls_bad && ctrl_r[`ULPM_CTRL_RESP_EN] && !i_tx_fifo_pending; // [RL9]
	assign dev_wake = !host_mode && dev_sleep_r && i_bus_resume;
	assign dev_resp_nxt = dev_stall ? ULPM_DRSP_STALL : (dev_ack ? ULPM_DRSP_ACK : ULPM_DRSP_NYET);

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_ep_r <= 3'h0;
			rx_ls_r <= 4'h0;
			rx_rwake_r <= 1'b0;
		end
		else if (dev_rx)
		begin
			rx_ep_r <= i_rx_endpoint_index; // [RL1]
			rx_ls_r <= i_rx_link_state; // [RL15]
			rx_rwake_r <= i_rx_remote_wake; // [RL17]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			dev_sleep_r <= 1'b0;
			dev_resp_valid_r <= 1'b0;
			dev_resp_r <= ULPM_DRSP_NYET;
			dev_rwake_r <= 1'b0;
		end
		else
		begin
			dev_sleep_r <= dev_ack || (dev_sleep_r && !dev_wake && !host_mode); // [RL9]
			dev_resp_valid_r <= dev_rx;
			dev_resp_r <= dev_rx ? dev_resp_nxt : dev_resp_r;
			dev_rwake_r <= cmd_wake && !host_mode && dev_sleep_r && rx_rwake_r;
		end
	end

	// ------------------------------------------------------------
	// host request sequencer
	// ------------------------------------------------------------
	ulpm_host_state_t hst_r;
	ulpm_host_state_t hst_nxt;
	logic [1:0] tries_r;
	logic [1:0] tries_nxt;
	logic req_r;
	logic req_nxt;
	logic [`ULPM_RES_CNT_W-1:0] rcnt_r;
	logic [`ULPM_RES_CNT_W-1:0] rcnt_nxt;
	logic [`ULPM_RES_CNT_W-1:0] res_load;
	logic [2:0] sent_ep_r;
	logic h_rsp;
	logic h_retry;
	logic [`ULPM_NFLAGS-1:0] h_set;

	// resume length: base plus one step per code, 50us..1175us
	assign res_load = `ULPM_RES_CNT_W'(P_RES_BASE_CYC + P_RES_STEP_CYC * int'(cfg_rtime)); // [RL19]
	assign h_rsp = (hst_r == ULPM_H_WAIT) && i_host_resp_valid && !i_host_bus_err;
	assign h_retry = h_rsp && ((i_host_resp == ULPM_HRSP_TIMEOUT) || (i_host_resp == ULPM_HRSP_BITERR));

	always_comb
	begin
		hst_nxt = hst_r;
		tries_nxt = tries_r;
		req_nxt = 1'b0;
		rcnt_nxt = rcnt_r;
		h_set = '0;
		case (hst_r)
			ULPM_H_IDLE:
			begin
				if (host_mode && cmd_send)
				begin
					hst_nxt = ULPM_H_WAIT;
					tries_nxt = 2'h1;
					req_nxt = 1'b1;
				end
			end
			ULPM_H_WAIT:
			begin
				if (i_host_bus_err)
				begin
					h_set[`ULPM_FLG_FAULT] = 1'b1; // [RL4]
					hst_nxt = ULPM_H_IDLE;
				end
				else if (h_retry)
				begin
					if (tries_r == `ULPM_MAX_ATTEMPTS)
					begin
						h_set[`ULPM_FLG_UNFIN] = 1'b1; // [RL3]
						hst_nxt = ULPM_H_IDLE;
					end
					else
					begin
						tries_nxt = tries_r + 2'h1;
						req_nxt = 1'b1;
					end
				end
				else if (h_rsp)
				begin
					hst_nxt = ULPM_H_IDLE;
					case (i_host_resp)
						ULPM_HRSP_ACK:
						begin
							h_set[`ULPM_FLG_ACCEPT] = 1'b1; // [RL5]
							hst_nxt = ULPM_H_SLEEP;
						end
						ULPM_HRSP_NYET: h_set[`ULPM_FLG_DEFER] = 1'b1; // [RL5]
						ULPM_HRSP_STALL: h_set[`ULPM_FLG_REFUSE] = 1'b1; // [RL5]
						default: h_set = '0;
					endcase
				end
			end
			ULPM_H_SLEEP:
			begin
				if (cmd_wake)
				begin
					hst_nxt = ULPM_H_RESUME;
					rcnt_nxt = res_load;
				end
				else if (i_bus_resume)
				begin
					// partner woke the link itself
					h_set[`ULPM_FLG_WAKEUP] = 1'b1; // [RL6]
					hst_nxt = ULPM_H_IDLE;
				end
			end
			ULPM_H_RESUME:
			begin
				rcnt_nxt = rcnt_r - `ULPM_RES_CNT_W'(1);
				if (rcnt_r == `ULPM_RES_CNT_W'(1))
				begin
					h_set[`ULPM_FLG_WAKEUP] = 1'b1; // [RL6]
					hst_nxt = ULPM_H_IDLE;
				end
			end
			default: hst_nxt = ULPM_H_IDLE;
		endcase
		if (!host_mode)
		begin
			// leaving host mode abandons any sequence
			hst_nxt = ULPM_H_IDLE;
			req_nxt = 1'b0;
			h_set = '0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			hst_r <= ULPM_H_IDLE;
			tries_r <= 2'h0;
			req_r <= 1'b0;
			rcnt_r <= '0;
			sent_ep_r <= 3'h0;
		end
		else
		begin
			hst_r <= hst_nxt;
			tries_r <= tries_nxt;
			req_r <= req_nxt;
			rcnt_r <= rcnt_nxt;
			sent_ep_r <= req_nxt ? cfg_endpoint : sent_ep_r; // [RL2]
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ctrl_r <= `ULPM_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_r <= ctrl_wr_val & ~(32'(dev_ack) << `ULPM_CTRL_RESP_EN); // [RL18]
		else if (dev_ack)
			ctrl_r[`ULPM_CTRL_RESP_EN] <= 1'b0; // [RL18]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ien_r <= '0;
		else if (wr_ien)
			ien_r <= i_wdata[`ULPM_NFLAGS-1:0]; // [RL21]
	end

	// ------------------------------------------------------------
	// event flags
	// ------------------------------------------------------------
	ulpm_flag_if fl ();
	logic [`ULPM_NFLAGS-1:0] dev_set;

	assign dev_set[`ULPM_FLG_FAULT] = dev_stall; // [RL7]
	assign dev_set[`ULPM_FLG_WAKEUP] = dev_wake; // [RL6]
	assign dev_set[`ULPM_FLG_UNFIN] = dev_nyet_busy; // [RL8]
	assign dev_set[`ULPM_FLG_ACCEPT] = dev_ack; // [RL9]
	assign dev_set[`ULPM_FLG_DEFER] = dev_nyet_off; // [RL10]
	assign dev_set[`ULPM_FLG_REFUSE] = dev_stall; // [RL11]

	assign fl.set = dev_set | h_set;
	assign fl.clr = rd_status; // [RL13]
	assign fl.mask = ien_r; // [RL12]

	ulpm_flag_bank u_flags (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.fl(fl.bank)
	);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [2:0] ep_view;
	logic [3:0] ls_view;
	logic rw_view;

	assign ep_view = host_mode ? sent_ep_r : rx_ep_r;
	assign ls_view = host_mode ? cfg_link_state : rx_ls_r; // [RL14] [RL15]
	assign rw_view = host_mode ? cfg_rwake : rx_rwake_r; // [RL16] [RL17]

	always_comb
	begin
		case (i_addr)
			`ULPM_OFS_CTRL: rdata_nxt = ctrl_r;
			`ULPM_OFS_STATUS: rdata_nxt = {26'h0, fl.flags};
			`ULPM_OFS_IEN: rdata_nxt = {26'h0, ien_r};
			`ULPM_OFS_ENDPOINT: rdata_nxt = {29'h0, ep_view}; // [RL1] [RL2]
			`ULPM_OFS_LINKSTATE: rdata_nxt = {28'h0, ls_view};
			`ULPM_OFS_RWAKE: rdata_nxt = {31'h0, rw_view};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rdata_r <= 32'h0000_0000;
		else
			rdata_r <= i_rd ? rdata_nxt : 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_rdata = rdata_r;
	assign o_irq = fl.irq;
	assign o_dev_resp_valid = dev_resp_valid_r;
	assign o_dev_resp = dev_resp_r;
	assign o_dev_remote_wake = dev_rwake_r;
	assign o_host_lpm_req = req_r;
	assign o_host_dev_addr = cfg_dev_addr; // [RL20]
	assign o_host_endpoint_index = sent_ep_r;
	assign o_host_link_state = cfg_link_state; // [RL14]
	assign o_host_remote_wake = cfg_rwake; // [RL16]
	assign o_resume_drive = hst_r == ULPM_H_RESUME;
	assign o_lpm_sleep = dev_sleep_r || (hst_r == ULPM_H_SLEEP) || (hst_r == ULPM_H_RESUME);

endmodule // ulpm_status

// ---- design/ulpm_cfg.svh ----
/*
 * Constants of the link power management status logic: register offsets,
 * field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef ULPM_CFG_SVH
`define ULPM_CFG_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ------------------------------------------------------------
`define ULPM_ADDR_W 8
`define ULPM_OFS_CTRL 8'h00
`define ULPM_OFS_CMD 8'h04
`define ULPM_OFS_STATUS 8'h08
`define ULPM_OFS_IEN 8'h0C
`define ULPM_OFS_ENDPOINT 8'h10
`define ULPM_OFS_LINKSTATE 8'h14
`define ULPM_OFS_RWAKE 8'h18

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define ULPM_CTRL_HOST 0
`define ULPM_CTRL_RESP_EN 1
`define ULPM_CTRL_RWAKE 2
`define ULPM_CTRL_LS_LO 4
`define ULPM_CTRL_EP_LO 8
`define ULPM_CTRL_ADDR_LO 12
`define ULPM_CTRL_RTIME_LO 20
`define ULPM_CTRL_RESET 32'h0000_1010

// ------------------------------------------------------------
// command register bits (write only, self clearing)
// ------------------------------------------------------------
`define ULPM_CMD_SEND 0
`define ULPM_CMD_WAKE 1

// ------------------------------------------------------------
// event flag positions, shared by status and enable
// ------------------------------------------------------------
`define ULPM_NFLAGS 6
`define ULPM_FLG_FAULT 0
`define ULPM_FLG_WAKEUP 1
`define ULPM_FLG_UNFIN 2
`define ULPM_FLG_ACCEPT 3
`define ULPM_FLG_DEFER 4
`define ULPM_FLG_REFUSE 5

// ------------------------------------------------------------
// link values and timing
// ------------------------------------------------------------
`define ULPM_SLEEP_LINK_STATE 4'h1
`define ULPM_MAX_ATTEMPTS 2'h3
`define ULPM_CLK_PERIOD_NS 8
`define ULPM_RES_BASE_US 50
`define ULPM_RES_STEP_US 75
`define ULPM_RES_BASE_CYC ((`ULPM_RES_BASE_US * 1000) / `ULPM_CLK_PERIOD_NS)
`define ULPM_RES_STEP_CYC ((`ULPM_RES_STEP_US * 1000) / `ULPM_CLK_PERIOD_NS)
`define ULPM_RES_CNT_W 18

`endif

// ---- design/ulpm_pkg.sv ----
/*
 * Types of the link power management status logic.
 * Assumes ulpm_cfg.svh on the include path.
 */
`include "ulpm_cfg.svh"

package ulpm_pkg;

	typedef enum logic [2:0]
	{
		ULPM_HRSP_ACK = 3'h0,
		ULPM_HRSP_NYET = 3'h1,
		ULPM_HRSP_STALL = 3'h2,
		ULPM_HRSP_TIMEOUT = 3'h3,
		ULPM_HRSP_BITERR = 3'h4
	} ulpm_host_resp_t;

	typedef enum logic [1:0]
	{
		ULPM_DRSP_ACK = 2'h0,
		ULPM_DRSP_NYET = 2'h1,
		ULPM_DRSP_STALL = 2'h2
	} ulpm_dev_resp_t;

	typedef enum logic [1:0]
	{
		ULPM_H_IDLE = 2'h0,
		ULPM_H_WAIT = 2'h1,
		ULPM_H_SLEEP = 2'h2,
		ULPM_H_RESUME = 2'h3
	} ulpm_host_state_t;

endpackage

// ---- design/ulpm_flag_if.sv ----
/*
 * Carrier between the control logic and the event flag bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`include "ulpm_cfg.svh"

interface ulpm_flag_if;
	logic [`ULPM_NFLAGS-1:0] set;
	logic clr;
	logic [`ULPM_NFLAGS-1:0] mask;
	logic [`ULPM_NFLAGS-1:0] flags;
	logic irq;

	modport ctl (output set, output clr, output mask, input flags, input irq);
	modport bank (input set, input clr, input mask, output flags, output irq);
endinterface

// ---- design/ulpm_flag_bank.sv ----
/*
 * Sticky event flags, cleared as a group, gated by a mask onto one request.
 * Assumes set and clear pulses synchronous to i_core_clk.
 */
`timescale 1ns/10ps

module ulpm_flag_bank
	import ulpm_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	ulpm_flag_if.bank fl
);

	logic [$bits(fl.flags)-1:0] flags_r;
	logic [$bits(fl.flags)-1:0] flags_nxt;

	// a new event in the clearing cycle survives
	assign flags_nxt = (fl.clr ? '0 : flags_r) | fl.set; // [RL13]

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			flags_r <= '0;
		else
			flags_r <= flags_nxt;
	end

	assign fl.flags = flags_r;
	assign fl.irq = |(flags_r & fl.mask); // [RL12]

endmodule // ulpm_flag_bank

// ---- bench/ulpm_status_props.sv ----
/*
 * Checker of the link power management status logic, bound to ulpm_status.
 * Assumes only the top ports, one clock, and ulpm_cfg.svh on the include path.
 */
`timescale 1ns/10ps
`include "ulpm_cfg.svh"

module ulpm_status_props
	import ulpm_pkg::*;
#(
	parameter int P_RES_BASE_CYC = `ULPM_RES_BASE_CYC,
	parameter int P_RES_STEP_CYC = `ULPM_RES_STEP_CYC
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [`ULPM_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic o_irq,
	input wire logic i_rx_lpm_valid,
	input wire logic [3:0] i_rx_link_state,
	input wire logic i_tx_fifo_pending,
	input wire logic o_dev_resp_valid,
	input wire ulpm_dev_resp_t o_dev_resp,
	input wire logic i_bus_resume,
	input wire logic o_host_lpm_req,
	input wire logic [2:0] o_host_endpoint_index,
	input wire logic [3:0] o_host_link_state,
	input wire logic o_host_remote_wake,
	input wire logic i_host_resp_valid,
	input wire ulpm_host_resp_t i_host_resp,
	input wire logic o_resume_drive,
	input wire logic o_lpm_sleep
);
	// ------------------------------------------------------------
	// shadows of software settings
	// ------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [5:0] ien_r;
	int cnt_r;
	wire dev_take = !ctrl_r[`ULPM_CTRL_HOST] && i_rx_lpm_valid && !o_lpm_sleep;
	wire ls_ok = i_rx_link_state == `ULPM_SLEEP_LINK_STATE;

	always_ff @(posedge i_core_clk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			ctrl_r <= `ULPM_CTRL_RESET;
			ien_r <= 6'h00;
			cnt_r <= 0;
		end
		else
		begin
			if (i_wr && i_addr == `ULPM_OFS_CTRL)
				ctrl_r <= i_wdata;
			if (i_wr && i_addr == `ULPM_OFS_IEN)
				ien_r <= i_wdata[5:0];
			cnt_r <= o_resume_drive ? cnt_r + 1 : 0;
		end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_cmd_send;
		$past(i_wr && i_addr == `ULPM_OFS_CMD && i_wdata[`ULPM_CMD_SEND]);
	endsequence
	sequence s_retry;
		$past(i_host_resp_valid && i_host_resp inside {ULPM_HRSP_TIMEOUT, ULPM_HRSP_BITERR});
	endsequence

	chk_dev_answer_time: assert property (
		dev_take |=> o_dev_resp_valid) else $error("device answer missing");
	chk_stall_bad_state: assert property (
		dev_take && !ls_ok |=> o_dev_resp == ULPM_DRSP_STALL) else $error("bad link state not stalled");
	chk_nyet_pending: assert property (
		dev_take && ls_ok && i_tx_fifo_pending |=> o_dev_resp == ULPM_DRSP_NYET) else $error("pending data acked");
	chk_ack_sleeps: assert property (
		o_dev_resp_valid && o_dev_resp == ULPM_DRSP_ACK |-> o_lpm_sleep) else $error("ack without sleep");
	chk_irq_masked: assert property (
		ien_r == 6'h00 |-> !o_irq) else $error("interrupt with all sources masked");
	chk_req_fields: assert property (
		o_host_lpm_req |-> o_host_link_state == ctrl_r[7:4] && o_host_remote_wake == ctrl_r[2]
		&& o_host_endpoint_index == ctrl_r[10:8]) else $error("request fields differ from setting");
	chk_req_cause: assert property (
		o_host_lpm_req |-> s_cmd_send or s_retry) else $error("request without send or retry");
	chk_resume_length: assert property (
		$fell(o_resume_drive) && ctrl_r[`ULPM_CTRL_HOST] |->
		cnt_r == P_RES_BASE_CYC + int'(ctrl_r[23:20]) * P_RES_STEP_CYC) else $error("resume length wrong");
	chk_wake_leaves: assert property (
		i_bus_resume && o_lpm_sleep && !o_resume_drive |=> !o_lpm_sleep) else $error("resume did not wake");
endmodule // ulpm_status_props

bind ulpm_status ulpm_status_props #(.P_RES_BASE_CYC(P_RES_BASE_CYC), .P_RES_STEP_CYC(P_RES_STEP_CYC))
	ulpm_status_props_i (.i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .o_irq, .i_rx_lpm_valid,
	.i_rx_link_state, .i_tx_fifo_pending, .o_dev_resp_valid, .o_dev_resp, .i_bus_resume, .o_host_lpm_req,
	.o_host_endpoint_index, .o_host_link_state, .o_host_remote_wake, .i_host_resp_valid, .i_host_resp,
	.o_resume_drive, .o_lpm_sleep);

// ---- bench/ulpm_partner.sv ----
/*
 * Far side model: a USB device answering host requests after a lag,
 * and a USB host that sends requests to the device role.
 * Assumes the link ports of ulpm_status and the same clock.
 */
`timescale 1ns/10ps

module ulpm_partner
	import ulpm_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_lpm_req,
	input wire ulpm_host_resp_t i_answer,
	input wire logic [1:0] i_lag,
	input wire logic i_berr,
	output logic o_resp_valid = 1'b0,
	output ulpm_host_resp_t o_resp = ULPM_HRSP_ACK,
	output logic o_bus_err = 1'b0,
	output logic o_rx_valid = 1'b0,
	output logic [2:0] o_rx_ep = 3'h0,
	output logic [3:0] o_rx_ls = 4'h0,
	output logic o_rx_rw = 1'b0
);
	int cnt = 0;

	// answer each attempt after i_lag + 1 idle cycles; code line scrambles when idle
	always @(posedge i_core_clk)
	begin
		o_resp_valid <= 1'b0;
		o_bus_err <= 1'b0;
		o_resp <= ulpm_host_resp_t'(~o_resp);
		if (!i_rst_n)
			cnt = 0;
		else if (i_lpm_req)
			cnt = i_lag + 1;
		else if (cnt > 0)
		begin
			cnt = cnt - 1;
			if (cnt == 0 && i_berr)
				o_bus_err <= 1'b1;
			else if (cnt == 0)
			begin
				o_resp_valid <= 1'b1;
				o_resp <= i_answer;
			end
		end
	end

	task send_req(input logic [2:0] ep, input logic [3:0] ls, input logic rw);
		@(posedge i_core_clk);
		o_rx_valid <= 1'b1;
		o_rx_ep <= ep;
		o_rx_ls <= ls;
		o_rx_rw <= rw;
		@(posedge i_core_clk);
		o_rx_valid <= 1'b0;
		o_rx_ep <= ~ep;
		o_rx_ls <= ~ls;
		o_rx_rw <= ~rw;
	endtask
endmodule // ulpm_partner

// ---- bench/ulpm_status_tb.sv ----
/*
 * Self-checking bench of ulpm_status with the far side model.
 * Assumes ulpm_cfg.svh, ulpm_pkg and ulpm_partner compiled before it.
 */
`timescale 1ns/10ps
`include "ulpm_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD %0t got %h exp %h", $time, (a), (e)); end end

module ulpm_status_tb
	import ulpm_pkg::*;
;
	localparam int PB = 4;
	localparam int PS = 3;
	logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_tx_fifo_pending = 1'b0;
	logic i_bus_resume = 1'b0, berr = 1'b0, rw;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, rdata, o_rdata;
	logic [1:0] lag = 2'h0;
	logic [2:0] ep, i_rx_endpoint_index, o_host_endpoint_index;
	logic [3:0] ls, n, i_rx_link_state, o_host_link_state;
	logic [5:0] ien, mflags = 6'h00;
	logic [6:0] ad, o_host_dev_addr;
	logic o_irq, i_rx_lpm_valid, i_rx_remote_wake, o_dev_resp_valid, o_host_lpm_req, o_host_remote_wake;
	logic i_host_resp_valid, i_host_bus_err, o_resume_drive, o_lpm_sleep, o_dev_remote_wake;
	ulpm_dev_resp_t o_dev_resp;
	ulpm_host_resp_t i_host_resp, answer = ULPM_HRSP_ACK;
	int miscompares = 0, check_count = 0, nreq = 0, cyc;
	ulpm_dev_resp_t xr [4] = '{ULPM_DRSP_STALL, ULPM_DRSP_NYET, ULPM_DRSP_NYET, ULPM_DRSP_ACK};
	logic [5:0] xf [4] = '{(6'h1 << `ULPM_FLG_FAULT) | (6'h1 << `ULPM_FLG_REFUSE), 6'h1 << `ULPM_FLG_DEFER,
		6'h1 << `ULPM_FLG_UNFIN, 6'h1 << `ULPM_FLG_ACCEPT};
	ulpm_host_resp_t ans [6] = '{ULPM_HRSP_NYET, ULPM_HRSP_STALL, ULPM_HRSP_TIMEOUT, ULPM_HRSP_BITERR,
		ULPM_HRSP_ACK, ULPM_HRSP_ACK};
	int hf [6] = '{`ULPM_FLG_DEFER, `ULPM_FLG_REFUSE, `ULPM_FLG_UNFIN, `ULPM_FLG_UNFIN, `ULPM_FLG_FAULT,
		`ULPM_FLG_ACCEPT};
	int nr [6] = '{1, 1, 3, 3, 1, 1};

	ulpm_status #(.P_RES_BASE_CYC(PB), .P_RES_STEP_CYC(PS)) ulpm_status_i (.i_core_clk, .i_rst_n, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_rx_lpm_valid, .i_rx_endpoint_index, .i_rx_link_state,
		.i_rx_remote_wake, .i_tx_fifo_pending, .o_dev_resp_valid, .o_dev_resp, .o_dev_remote_wake,
		.i_bus_resume, .o_host_lpm_req, .o_host_dev_addr, .o_host_endpoint_index, .o_host_link_state,
		.o_host_remote_wake, .i_host_resp_valid, .i_host_resp, .i_host_bus_err, .o_resume_drive, .o_lpm_sleep);
	ulpm_partner ulpm_partner_i (.i_core_clk, .i_rst_n, .i_lpm_req(o_host_lpm_req), .i_answer(answer),
		.i_lag(lag), .i_berr(berr), .o_resp_valid(i_host_resp_valid), .o_resp(i_host_resp),
		.o_bus_err(i_host_bus_err), .o_rx_valid(i_rx_lpm_valid), .o_rx_ep(i_rx_endpoint_index),
		.o_rx_ls(i_rx_link_state), .o_rx_rw(i_rx_remote_wake));

	always #4 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk)
		if (o_host_lpm_req === 1'b1)
			nreq++;

	// ------------------------------------------------------------
	// register port and closing
	// ------------------------------------------------------------
	task conclude;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 rdata = o_rdata;
		`CHK(rdata, e)
	endtask
	task stat;
		rchk(`ULPM_OFS_STATUS, {26'h0, mflags});
		mflags = 6'h00;
	endtask

	initial
	begin
		void'($urandom(98));
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rchk(`ULPM_OFS_CTRL, `ULPM_CTRL_RESET);
		`CHK(o_host_dev_addr, 7'h01)
		wr(8'h1C, 32'hFFFF_FFFF);
		rchk(8'h1C, 32'h0);
		stat();
		// device role: stall, disabled, pending data, acknowledge
		for (int k = 0; k < 4; k++)
		begin
			ls = (k == 0) ? 4'(2 + $urandom % 14) : `ULPM_SLEEP_LINK_STATE;
			ep = 3'($urandom);
			rw = 1'($urandom);
			ien = 6'($urandom);
			wr(`ULPM_OFS_CTRL, `ULPM_CTRL_RESET | ((k >= 2) << `ULPM_CTRL_RESP_EN));
			wr(`ULPM_OFS_IEN, {26'h0, ien});
			i_tx_fifo_pending <= (k == 2);
			ulpm_partner_i.send_req(ep, ls, rw);
			#1 mflags = mflags | xf[k];
			`CHK(o_dev_resp_valid, 1'b1)
			`CHK(o_dev_resp, xr[k])
			`CHK(o_irq, |(mflags & ien))
			rchk(`ULPM_OFS_ENDPOINT, {29'h0, ep});
			rchk(`ULPM_OFS_LINKSTATE, {28'h0, ls});
			rchk(`ULPM_OFS_RWAKE, {31'h0, rw});
			stat();
			stat();
		end
		`CHK(o_lpm_sleep, 1'b1)
		rchk(`ULPM_OFS_CTRL, `ULPM_CTRL_RESET);
		wr(`ULPM_OFS_CMD, 32'h2);
		#1 `CHK(o_dev_remote_wake, rw)
		@(posedge i_core_clk);
		i_bus_resume <= 1'b1;
		@(posedge i_core_clk);
		i_bus_resume <= 1'b0;
		#1 `CHK(o_lpm_sleep, 1'b0)
		mflags = 6'h1 << `ULPM_FLG_WAKEUP;
		stat();
		// host role: every answer kind, retries, bus error, then resume
		n = 4'($urandom);
		ep = 3'($urandom);
		ad = 7'(1 + $urandom % 127);
		rw = 1'($urandom);
		wr(`ULPM_OFS_CTRL, {8'h0, n, 1'b0, ad, 1'b0, ep, `ULPM_SLEEP_LINK_STATE, 1'b0, rw, 2'b01});
		wr(`ULPM_OFS_IEN, 32'h3F);
		for (int k = 0; k < 6; k++)
		begin
			answer <= ans[k];
			berr <= (k == 4);
			lag <= 2'($urandom);
			nreq = 0;
			wr(`ULPM_OFS_CMD, 32'h1);
			cyc = 0;
			while (o_irq !== 1'b1 && cyc < 100)
				@(posedge i_core_clk) #1 cyc++;
			if (cyc == 100)
			begin
				miscompares++;
				conclude();
			end
			`CHK(nreq, nr[k])
			mflags = 6'h1 << hf[k];
			stat();
		end
		`CHK(o_lpm_sleep, 1'b1)
		`CHK(o_host_dev_addr, ad)
		rchk(`ULPM_OFS_ENDPOINT, {29'h0, ep});
		rchk(`ULPM_OFS_LINKSTATE, 32'(`ULPM_SLEEP_LINK_STATE));
		rchk(`ULPM_OFS_RWAKE, {31'h0, rw});
		wr(`ULPM_OFS_CMD, 32'h2);
		#1 cyc = 0;
		while (o_resume_drive === 1'b1 && cyc < 200)
			@(posedge i_core_clk) #1 cyc++;
		`CHK(cyc, PB + PS * n)
		`CHK(o_lpm_sleep, 1'b0)
		mflags = 6'h1 << `ULPM_FLG_WAKEUP;
		stat();
		conclude();
	end
endmodule // ulpm_status_tb
